/* hdl/sci_pkg.sv */
/*
  Constants, register map and helper functions for the sinusoidal encoder
  interpolator. Assumes a 32-bit APB register bus and byte addressing.
*/
package sci_pkg;

  // ==========================================================================
  // Widths
  localparam int SCI_ADC_W = 16;
  localparam int SCI_CNT_W = 24;
  localparam int SCI_ANG_W = 14;
  localparam int SCI_FRAC_W = 12;
  localparam int SCI_LEG_FRAC_W = 8;
  localparam int SCI_ITER = 12;
  localparam int SCI_ROT_W = SCI_ADC_W + 3;

  // ==========================================================================
  // Register map, byte offsets inside one channel window
  localparam int SCI_CH_SHIFT = 5;
  localparam logic [4:0] SCI_OFS_CTRL = 5'h00;
  localparam logic [4:0] SCI_OFS_BIAS0 = 5'h04;
  localparam logic [4:0] SCI_OFS_BIAS1 = 5'h08;
  localparam logic [4:0] SCI_OFS_SERVO = 5'h0C;
  localparam logic [4:0] SCI_OFS_PHASE = 5'h10;
  localparam logic [4:0] SCI_OFS_ADC = 5'h14;
  localparam logic [4:0] SCI_OFS_COUNT = 5'h18;

  // ==========================================================================
  // Control fields and reset values
  localparam int SCI_DSEL_LSB = 0;
  localparam int SCI_ATAN_BIT = 4;
  localparam int SCI_TMODE_BIT = 5;
  localparam logic [3:0] SCI_DSEL_X4_CW = 4'h3;
  localparam logic [3:0] SCI_DSEL_X4_CCW = 4'h7;
  localparam logic [31:0] SCI_CTRL_RST = 32'h0000_0003;
  localparam logic [15:0] SCI_BIAS_RST = 16'h0000;
  localparam logic [31:0] SCI_LATCH_RST = 32'h0000_0000;
  localparam logic [7:0] SCI_LEG_HALF = 8'h80;
  localparam logic [13:0] SCI_HALF_TURN = 14'h2000;

  typedef enum {SCI_IDLE, SCI_WAIT_ADC, SCI_ROTATE, SCI_WRITE} sci_state_type;

  // Arctangent of 2^-i in units of 1/16384 turn.
  function automatic logic [13:0] sci_atan_step(input logic [3:0] i);
    case (i)
      4'd0: sci_atan_step = 14'h0800;
      4'd1: sci_atan_step = 14'h04B9;
      4'd2: sci_atan_step = 14'h027F;
      4'd3: sci_atan_step = 14'h0144;
      4'd4: sci_atan_step = 14'h00A3;
      4'd5: sci_atan_step = 14'h0051;
      4'd6: sci_atan_step = 14'h0029;
      4'd7: sci_atan_step = 14'h0014;
      4'd8: sci_atan_step = 14'h000A;
      4'd9: sci_atan_step = 14'h0005;
      4'd10: sci_atan_step = 14'h0003;
      4'd11: sci_atan_step = 14'h0001;
      default: sci_atan_step = 14'h0000;
    endcase
  endfunction : sci_atan_step

  // Gray quadrature state to a 0..3 phase index.
  function automatic logic [1:0] sci_quad_index(input logic a, input logic b);
    sci_quad_index = {a, a ^ b};
  endfunction : sci_quad_index

endpackage : sci_pkg

/* hdl/sci_interp.sv */
/*
  Sinusoidal encoder interpolator: per channel x4 quadrature decode, biased
  ADC samples, arctangent by shift-add rotation, and servo and phase latches
  of the merged 32-bit position, all behind an APB slave.
  Assumes quadrature and event pins are asynchronous, and that the ADC
  front end runs on sys_clk_i and answers each sample request with a
  one-cycle adc_valid_i carrying every channel's sine and cosine.
*/
// Function
// - Select 3 or 7: x4 decode, two senses.
// - Arctan enable uses ADC arctangent as fraction.
// - Arctan on: low twelve latch bits hold the fraction.
// - Latch word on servo and phase events.
// - Add bias offsets to sine and cosine.
// - Bias only, no gain or phase correction.
// - Arctan off: no fraction merge, bias ignored.
// - Arctan off: eight fraction bits, half count.
// - Timer mode zero keeps timer fraction for capture.
// - All channels computed concurrently, one word each.
// - Fast quadrature decode, ADC sampled every event.
`timescale 1ns/1ns
`default_nettype none

module sci_interp
  import sci_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [NCH-1:0] quad_a_i,
  input wire logic [NCH-1:0] quad_b_i,
  input wire logic servo_evt_i,
  input wire logic phase_evt_i,
  output logic adc_sample_o,
  input wire logic adc_valid_i,
  input wire logic [NCH*SCI_ADC_W-1:0] adc_sin_i,
  input wire logic [NCH*SCI_ADC_W-1:0] adc_cos_i,
  output logic [NCH-1:0] timer_fraction_mode_o
);

  // The channel field of the address is three bits wide.
  if (NCH < 1 || NCH > 8) begin : g_bad_nch
    $error("sci_interp: NCH must be 1 to 8");
  end

  // ==========================================================================
  // Event pins
  logic [2:0] servo_sync_r;
  logic [2:0] phase_sync_r;
  wire logic servo_evt = servo_sync_r[1] & ~servo_sync_r[2];
  wire logic phase_evt = phase_sync_r[1] & ~phase_sync_r[2];
  wire logic any_evt = servo_evt | phase_evt;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      servo_sync_r <= 3'b000;
      phase_sync_r <= 3'b000;
    end else begin
      servo_sync_r <= {servo_sync_r[1:0], servo_evt_i};
      phase_sync_r <= {phase_sync_r[1:0], phase_evt_i};
    end
  end

  assign adc_sample_o = any_evt;

  // ==========================================================================
  // APB decode
  wire logic [2:0] ch_sel = paddr_i[7:SCI_CH_SHIFT];
  wire logic [4:0] ofs_sel = paddr_i[SCI_CH_SHIFT-1:0];
  wire logic ofs_ok = (ofs_sel == SCI_OFS_CTRL) || (ofs_sel == SCI_OFS_BIAS0)
    || (ofs_sel == SCI_OFS_BIAS1) || (ofs_sel == SCI_OFS_SERVO)
    || (ofs_sel == SCI_OFS_PHASE) || (ofs_sel == SCI_OFS_ADC)
    || (ofs_sel == SCI_OFS_COUNT);
  wire logic addr_ok = ofs_ok && ({29'h0000_0000, ch_sel} < NCH);
  wire logic setup = psel_i & ~penable_i;
  wire logic wr_acc = psel_i & penable_i & pwrite_i & addr_ok;

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;

  // ==========================================================================
  // Register storage
  logic [31:0] ctrl_r [NCH];
  logic [15:0] bias0_r [NCH];
  logic [15:0] bias1_r [NCH];
  logic [31:0] servo_r [NCH];
  logic [31:0] phase_r [NCH];
  logic [31:0] adc_r [NCH];
  logic [SCI_CNT_W-1:0] count_r [NCH];
  logic [31:0] rd_word;

  // Byte-lane merge shared by every writable register.
  function automatic logic [31:0] sci_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      sci_merge[b*8 +: 8] = st[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : sci_merge

  // Bias registers keep only the two low byte lanes of a written word.
  function automatic logic [15:0] sci_low_half(input logic [31:0] w);
    sci_low_half = w[15:0];
  endfunction : sci_low_half

  // ==========================================================================
  // Read path
  always_comb begin
    rd_word = 32'h0000_0000;
    for (int c = 0; c < NCH; c++) begin
      if (ch_sel == c[2:0]) begin
        case (ofs_sel)
          SCI_OFS_CTRL: rd_word = ctrl_r[c];
          SCI_OFS_BIAS0: rd_word = {16'h0000, bias0_r[c]};
          SCI_OFS_BIAS1: rd_word = {16'h0000, bias1_r[c]};
          SCI_OFS_SERVO: rd_word = servo_r[c];
          SCI_OFS_PHASE: rd_word = phase_r[c];
          SCI_OFS_ADC: rd_word = adc_r[c];
          SCI_OFS_COUNT: rd_word = {8'h00, count_r[c]};
          default: rd_word = 32'h0000_0000;
        endcase
      end
    end
  end

  // Read data is captured in the setup cycle so it is a flop output.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup) begin
      prdata_o <= addr_ok ? rd_word : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Register writes
  // Unused control bits stay zero, so reserved bits always read back as zero.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_r[c] <= SCI_CTRL_RST;
        bias0_r[c] <= SCI_BIAS_RST;
        bias1_r[c] <= SCI_BIAS_RST;
      end
    end else if (wr_acc) begin
      for (int c = 0; c < NCH; c++) begin
        if (ch_sel == c[2:0]) begin
          if (ofs_sel == SCI_OFS_CTRL) begin
            ctrl_r[c] <= sci_merge(ctrl_r[c], pwdata_i, pstrb_i)
              & 32'h0000_003F;
          end
          if (ofs_sel == SCI_OFS_BIAS0) begin
            bias0_r[c] <= sci_low_half(sci_merge({16'h0000, bias0_r[c]},
              pwdata_i, pstrb_i));
          end
          if (ofs_sel == SCI_OFS_BIAS1) begin
            bias1_r[c] <= sci_low_half(sci_merge({16'h0000, bias1_r[c]},
              pwdata_i, pstrb_i));
          end
        end
      end
    end
  end

  // ==========================================================================
  // Per-channel datapath
  // One independent datapath per channel
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [1:0] qa_r;
    logic [1:0] qb_r;
    logic [1:0] qidx_r;
    logic [1:0] snap_q_r;
    logic [SCI_CNT_W-1:0] snap_cnt_r;
    logic servo_pend_r;
    logic phase_pend_r;
    sci_state_type state_r;
    logic [3:0] iter_r;
    logic signed [SCI_ROT_W-1:0] x_r;
    logic signed [SCI_ROT_W-1:0] y_r;
    logic [SCI_ANG_W-1:0] z_r;

    wire logic [3:0] dsel = ctrl_r[g][SCI_DSEL_LSB +: 4];
    wire logic atan_en = ctrl_r[g][SCI_ATAN_BIT];
    wire logic reverse = (dsel == SCI_DSEL_X4_CCW);
    wire logic dec_ok = (dsel == SCI_DSEL_X4_CW) || reverse;
    wire logic [1:0] raw_q = sci_quad_index(qa_r[1], qb_r[1]);
    wire logic [1:0] dir_q = reverse ? 2'(-raw_q) : raw_q;
    wire logic [1:0] step = 2'(dir_q - qidx_r);

    wire logic [SCI_ADC_W-1:0] sin_s = adc_sin_i[g*SCI_ADC_W +: SCI_ADC_W];
    wire logic [SCI_ADC_W-1:0] cos_s = adc_cos_i[g*SCI_ADC_W +: SCI_ADC_W];
    wire logic signed [SCI_ROT_W-1:0] sin_b = SCI_ROT_W'($signed(sin_s))
      + SCI_ROT_W'($signed(bias0_r[g]));
    wire logic signed [SCI_ROT_W-1:0] cos_b = SCI_ROT_W'($signed(cos_s))
      + SCI_ROT_W'($signed(bias1_r[g]));

    wire logic signed [SCI_ROT_W-1:0] xs = x_r >>> iter_r;
    wire logic signed [SCI_ROT_W-1:0] ys = y_r >>> iter_r;
    wire logic [SCI_ANG_W-1:0] ang = reverse ? 14'(-z_r) : z_r;

    // Count pulled to the arctangent quadrant
    wire logic [1:0] qdiff = 2'(ang[SCI_ANG_W-1 -: 2] - snap_q_r);
    wire logic [SCI_CNT_W-1:0] whole = snap_cnt_r
      + {{(SCI_CNT_W-2){qdiff[1]}}, qdiff};
    wire logic [31:0] atan_word = {whole[31-SCI_FRAC_W:0],
      ang[SCI_FRAC_W-1:0]};
    wire logic [31:0] leg_word = {count_r[g], SCI_LEG_HALF};

    // Timer fraction mode passed to capture logic
    assign timer_fraction_mode_o[g] = ctrl_r[g][SCI_TMODE_BIT];

    // ========================================================================
    // Quadrature decode
    // Quadrature sampled every clock
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        qa_r <= 2'b00;
        qb_r <= 2'b00;
        qidx_r <= 2'b00;
        count_r[g] <= '0;
      end else begin
        qa_r <= {qa_r[0], quad_a_i[g]};
        qb_r <= {qb_r[0], quad_b_i[g]};
        qidx_r <= dir_q;
        if (dec_ok && step == 2'd1) begin
          count_r[g] <= count_r[g] + 1'b1;
        end else if (dec_ok && step == 2'd3) begin
          count_r[g] <= count_r[g] - 1'b1;
        end
      end
    end

    // ========================================================================
    // Arctangent sequencer
    // The rotation runs a fixed 12 cycles, so only the ADC wait varies the latency.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        state_r <= SCI_IDLE;
        iter_r <= 4'h0;
        x_r <= '0;
        y_r <= '0;
        z_r <= '0;
        snap_cnt_r <= '0;
        snap_q_r <= 2'b00;
        servo_pend_r <= 1'b0;
        phase_pend_r <= 1'b0;
        servo_r[g] <= SCI_LATCH_RST;
        phase_r[g] <= SCI_LATCH_RST;
        adc_r[g] <= 32'h0000_0000;
      end else begin
        if (adc_valid_i) begin
          adc_r[g] <= {cos_s, sin_s};
        end
        case (state_r)
          SCI_IDLE: begin
            if (any_evt && atan_en) begin
              snap_cnt_r <= count_r[g];
              snap_q_r <= qidx_r;
              servo_pend_r <= servo_evt;
              phase_pend_r <= phase_evt;
              state_r <= SCI_WAIT_ADC;
            end else if (any_evt) begin
              if (servo_evt) begin
                servo_r[g] <= leg_word;
              end
              if (phase_evt) begin
                phase_r[g] <= leg_word;
              end
            end
          end
          SCI_WAIT_ADC: begin
            servo_pend_r <= servo_pend_r | servo_evt;
            phase_pend_r <= phase_pend_r | phase_evt;
            if (adc_valid_i) begin
              // Fold the left half-plane over so the rotation converges.
              x_r <= cos_b[SCI_ROT_W-1] ? -cos_b : cos_b;
              y_r <= cos_b[SCI_ROT_W-1] ? -sin_b : sin_b;
              z_r <= cos_b[SCI_ROT_W-1] ? SCI_HALF_TURN : '0;
              iter_r <= 4'h0;
              state_r <= SCI_ROTATE;
            end
          end
          SCI_ROTATE: begin
            servo_pend_r <= servo_pend_r | servo_evt;
            phase_pend_r <= phase_pend_r | phase_evt;
            if (y_r >= 0) begin
              x_r <= x_r + ys;
              y_r <= y_r - xs;
              z_r <= z_r + sci_atan_step(iter_r);
            end else begin
              x_r <= x_r - ys;
              y_r <= y_r + xs;
              z_r <= z_r - sci_atan_step(iter_r);
            end
            iter_r <= iter_r + 1'b1;
            if (iter_r == 4'(SCI_ITER - 1)) begin
              state_r <= SCI_WRITE;
            end
          end
          SCI_WRITE: begin
            if (servo_pend_r) begin
              servo_r[g] <= atan_word;
            end
            if (phase_pend_r) begin
              phase_r[g] <= atan_word;
            end
            // An event in this cycle opens a new round while arctan is enabled; with arctan off it is dropped.
            servo_pend_r <= servo_evt;
            phase_pend_r <= phase_evt;
            snap_cnt_r <= count_r[g];
            snap_q_r <= qidx_r;
            state_r <= (any_evt && atan_en) ? SCI_WAIT_ADC : SCI_IDLE;
          end
          default: state_r <= SCI_IDLE;
        endcase
      end
    end
  end

endmodule : sci_interp

`default_nettype wire

/* verification/sci_interp_assertions.sv */
/*
  Checker for the interpolator: port-level properties of events and APB.
  Assumes it is bound to sci_interp and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none

module sci_interp_chk
  import sci_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic servo_evt_i,
  input wire logic phase_evt_i,
  input wire logic adc_sample_o,
  input wire logic [NCH-1:0] timer_fraction_mode_o
);
  // ==========================================================================
  // Helper logic
  logic [3:0] since_r;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      since_r <= 4'hF;
    end else if ($rose(servo_evt_i) || $rose(phase_evt_i)) begin
      since_r <= 4'h0;
    end else if (since_r != 4'hF) begin
      since_r <= since_r + 4'h1;
    end
  end

  // ==========================================================================
  // Properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_acc;
    psel_i && penable_i;
  endsequence
  sequence s_ctrl0_wr;
    s_acc ##0 (pwrite_i && paddr_i == 8'h00 && pstrb_i[0]);
  endsequence

  chk_servo_sample: assert property (
    $rose(servo_evt_i) |-> ##[1:6] adc_sample_o)
    else $error("no sample after servo event");
  chk_phase_sample: assert property (
    $rose(phase_evt_i) |-> ##[1:6] adc_sample_o)
    else $error("no sample after phase event");
  chk_sample_cause: assert property (adc_sample_o |-> since_r <= 4'd6)
    else $error("sample without event");
  chk_sample_pulse: assert property (adc_sample_o |=> !adc_sample_o)
    else $error("sample pulse too long");
  chk_tmode_write: assert property (s_ctrl0_wr |=>
    timer_fraction_mode_o[0] == $past(pwdata_i[SCI_TMODE_BIT]))
    else $error("timer mode not written");
  chk_tmode_reset: assert property (
    $fell(rst_i) |-> timer_fraction_mode_o == '0)
    else $error("timer mode not zero after reset");
  chk_unmap_err: assert property (s_acc ##0 (paddr_i[7:5] >= NCH) |->
    pslverr_o && (pwrite_i || prdata_o == 32'h0000_0000))
    else $error("unmapped access not refused");
  chk_map_ok: assert property (s_acc ##0 (paddr_i[7:5] < NCH) ##0
    (paddr_i[4:0] <= SCI_OFS_COUNT && paddr_i[1:0] == 2'b00) |-> !pslverr_o)
    else $error("mapped access refused");
  chk_ready_high: assert property (s_acc |-> pready_o)
    else $error("access not completed");
endmodule : sci_interp_chk

bind sci_interp sci_interp_chk #(.NCH(NCH)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .servo_evt_i(servo_evt_i),
  .phase_evt_i(phase_evt_i), .adc_sample_o(adc_sample_o),
  .timer_fraction_mode_o(timer_fraction_mode_o));

`default_nettype wire

/* verification/sci_adc_model.sv */
/*
  Behavioural model of the encoder ADC front end.
  Assumes one sample request pulse per event and a latency set by the bench.
*/
`timescale 1ns/1ns
`default_nettype none

module sci_adc_model
  import sci_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic sample_i,
  input wire logic [3:0] lat_i,
  input wire logic [NCH*SCI_ADC_W-1:0] sin_set_i,
  input wire logic [NCH*SCI_ADC_W-1:0] cos_set_i,
  output logic valid_o,
  output logic [NCH*SCI_ADC_W-1:0] sin_o,
  output logic [NCH*SCI_ADC_W-1:0] cos_o
);
  logic busy_r;
  logic [3:0] wait_r;
  // ==========================================================================
  // Conversion
  // one conversion per event.
  // Outside the valid cycle the data toggle, so stale values never pass.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      wait_r <= 4'h0;
      valid_o <= 1'b0;
      sin_o <= '0;
      cos_o <= '0;
    end else begin
      valid_o <= 1'b0;
      sin_o <= ~sin_o;
      cos_o <= ~cos_o;
      if (sample_i) begin
        busy_r <= 1'b1;
        wait_r <= lat_i;
      end else if (busy_r && wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        valid_o <= 1'b1;
        sin_o <= sin_set_i;
        cos_o <= cos_set_i;
      end
    end
  end
endmodule : sci_adc_model

`default_nettype wire

/* verification/tb_top.sv */
/*
  Self-checking bench for the interpolator with two channels.
  Assumes the ADC model answers each sample request.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top
  import sci_pkg::*;
();
  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, servo = 1'b0, phase = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, r;
  logic [1:0] qa = 2'b00, qb = 2'b00, tmode, idx [2];
  logic [3:0] lat = 4'h1;
  logic [31:0] sin_set = 32'h0, cos_set = 32'h0, prdata, adc_sin, adc_cos;
  logic pready, pslverr, smp, vld;
  int miscompares = 0, comparisons = 0, cycles = 0;

  sci_interp #(.NCH(2)) DUT (.sys_clk_i(sys_clk), .rst_i(rst),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .quad_a_i(qa), .quad_b_i(qb), .servo_evt_i(servo),
    .phase_evt_i(phase), .adc_sample_o(smp), .adc_valid_i(vld),
    .adc_sin_i(adc_sin), .adc_cos_i(adc_cos), .timer_fraction_mode_o(tmode));
  sci_adc_model #(.NCH(2)) u_adc (.sys_clk_i(sys_clk), .rst_i(rst),
    .sample_i(smp), .lat_i(lat), .sin_set_i(sin_set), .cos_set_i(cos_set),
    .valid_o(vld), .sin_o(adc_sin), .cos_o(adc_cos));

  // ==========================================================================
  // Clock, timeout and closing
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // ==========================================================================
  // Compare and access tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // The arctangent is iterative, so a few LSBs of error are tolerated.
  task automatic check_near(input logic [31:0] got, input logic [31:0] exp);
    logic signed [31:0] d;
    d = got - exp;
    comparisons++;
    if (^got === 1'bx || d > 4 || d < -4) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_near
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [7:0] ad(input int ch, input logic [4:0] o);
    return {ch[2:0], o};
  endfunction : ad
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
  endtask : rdc
  task automatic step(input int ch, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      idx[ch] = idx[ch] + 2'd1;
      qa[ch] <= idx[ch][1];
      qb[ch] <= idx[ch][1] ^ idx[ch][0];
      repeat (4) @(posedge sys_clk);
    end
  endtask : step
  task automatic evt(input logic ph);
    @(posedge sys_clk);
    if (ph) phase <= 1'b1;
    else servo <= 1'b1;
    repeat (3) @(posedge sys_clk);
    phase <= 1'b0;
    servo <= 1'b0;
    repeat (40) @(posedge sys_clk);
  endtask : evt

  // ==========================================================================
  // Tests
  initial begin
    idx[0] = 2'd0;
    idx[1] = 2'd0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(ad(0, SCI_OFS_CTRL), SCI_CTRL_RST);
    rdc(ad(1, SCI_OFS_BIAS0), 32'h0000_0000);
    rdc(ad(0, SCI_OFS_SERVO), SCI_LATCH_RST);
    check({30'h0, tmode}, 32'h0000_0000);
    apb(1'b1, 8'h40, 32'h1234_5678);
    check({31'h0, e}, 32'h0000_0001);
    rdc(8'h40, 32'h0000_0000);
    check({31'h0, e}, 32'h0000_0001);
    apb(1'b1, ad(0, SCI_OFS_CTRL), 32'h0000_0023);
    // The control write lands at the access edge; look one edge later.
    @(posedge sys_clk);
    check({30'h0, tmode}, 32'h0000_0001);
    apb(1'b1, ad(0, SCI_OFS_CTRL), 32'h0000_0003);
    $display("test registers done");
    apb(1'b1, ad(1, SCI_OFS_CTRL), 32'h0000_0007);
    step(0, 5);
    step(1, 3);
    rdc(ad(0, SCI_OFS_COUNT), 32'h0000_0005);
    rdc(ad(1, SCI_OFS_COUNT), 32'h00FF_FFFD);
    apb(1'b1, ad(1, SCI_OFS_CTRL), 32'h0000_0000);
    step(1, 2);
    rdc(ad(1, SCI_OFS_COUNT), 32'h00FF_FFFD);
    $display("test counting done");
    apb(1'b1, ad(0, SCI_OFS_BIAS0), 32'h0000_1000);
    evt(1'b0);
    rdc(ad(0, SCI_OFS_SERVO), {24'd5, SCI_LEG_HALF});
    evt(1'b1);
    rdc(ad(0, SCI_OFS_PHASE), {24'd5, SCI_LEG_HALF});
    $display("test no arctangent done");
    step(0, 3);
    apb(1'b1, ad(0, SCI_OFS_BIAS0), 32'h0000_FF00);
    apb(1'b1, ad(0, SCI_OFS_BIAS1), 32'h0000_0100);
    apb(1'b1, ad(0, SCI_OFS_CTRL), 32'h0000_0013);
    apb(1'b1, ad(1, SCI_OFS_CTRL), 32'h0000_0013);
    sin_set <= 32'h2000_2100;
    cos_set <= 32'hE000_1F00;
    evt(1'b0);
    apb(1'b0, ad(0, SCI_OFS_SERVO), 32'h0);
    check_near(r, 32'h0000_8800);
    cos_set <= 32'hE000_DF00;
    lat <= 4'h9;
    evt(1'b1);
    apb(1'b0, ad(0, SCI_OFS_PHASE), 32'h0);
    check_near(r, 32'h0000_9800);
    apb(1'b0, ad(1, SCI_OFS_PHASE), 32'h0);
    check_near(r, 32'hFFFF_D800);
    $display("test arctangent done");
    test_done();
  end
endmodule : tb_top

`default_nettype wire
